/* rtl/brag_addr_gen.sv */
// Write-side effective-address generator with bit-reversed and modulo modes
`timescale 1ns/1ps
module brag_addr_gen
    import brag_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int PTR_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_byte,
    input wire logic [3:0] req_wreg,
    input wire logic [2:0] req_mode,
    input wire logic [PTR_W-1:0] req_ptr,
    input wire logic [PTR_W-1:0] req_offset,
    output logic ea_valid,
    output logic [PTR_W-1:0] ea_addr,
    output logic ea_reversed,
    output logic ptr_wb_en,
    output logic [3:0] ptr_wb_reg,
    output logic [PTR_W-1:0] ptr_wb_value
);

    // Register storage
    logic [15:0] rev_ctrl_q;
    logic [15:0] mod_ctrl_q;
    logic [PTR_W-1:0] mod_start_q;
    logic [PTR_W-1:0] mod_end_q;

    // AXI channel state
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // Address result registers
    logic ea_valid_q;
    logic [PTR_W-1:0] ea_addr_q;
    logic ea_reversed_q;
    logic wb_en_q;
    logic [3:0] wb_reg_q;
    logic [PTR_W-1:0] wb_value_q;

    // Combinational address path
    logic [BRAG_SEL_W-1:0] ptr_sel;
    logic [BRAG_SEL_W-1:0] mod_sel;
    logic reverse_enable;
    logic [BRAG_PIVOT_W-1:0] pivot_modifier;
    logic brev_cfg_ok;
    logic inc_mode;
    logic dec_mode;
    logic pre_mode;
    logic use_brev;
    logic use_mod;
    logic [PTR_W-1:0] step;
    logic [PTR_W-1:0] raw_next;
    logic [PTR_W-1:0] mod_len;
    logic [PTR_W-1:0] mod_next;
    logic [PTR_W-2:0] rev_word;
    logic [PTR_W-1:0] rev_next;
    logic [PTR_W-1:0] next_ptr;
    logic [PTR_W-1:0] ea_d;
    logic wb_d;

    // Write handshake and read decode helpers
    logic aw_take;
    logic w_take;
    logic do_write;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;

    assign ptr_sel = mod_ctrl_q[BRAG_PTR_SEL_LSB +: BRAG_SEL_W];
    assign mod_sel = mod_ctrl_q[BRAG_MOD_SEL_LSB +: BRAG_SEL_W];
    assign reverse_enable = rev_ctrl_q[BRAG_REVERSE_ENABLE_BIT];
    assign pivot_modifier = rev_ctrl_q[BRAG_PIVOT_MSB:0]; // RULE7

    // Conditions under which reversal is allowed at all
    assign brev_cfg_ok = reverse_enable && (ptr_sel != BRAG_STACK_PTR); // RULE3 RULE4
    assign inc_mode = (req_mode == BRAG_MODE_PRE_INC) || (req_mode == BRAG_MODE_POST_INC); // RULE5
    assign dec_mode = (req_mode == BRAG_MODE_PRE_DEC) || (req_mode == BRAG_MODE_POST_DEC);
    assign pre_mode = (req_mode == BRAG_MODE_PRE_INC) || (req_mode == BRAG_MODE_PRE_DEC);

    // Reversal only on word data writes through the selected pointer
    // A control write takes effect at the next request; software keeps a read
    // through the reversed pointer away from it, so no hazard logic is spent here
    assign use_brev = req_write && !req_byte && inc_mode && brev_cfg_ok
        && (req_wreg == ptr_sel); // RULE1 RULE9
    assign use_mod = mod_ctrl_q[BRAG_MOD_ENABLE_BIT] && (req_wreg == mod_sel);

    // Normal increment follows the data size
    assign step = req_byte ? PTR_W'(1) : PTR_W'(2);
    assign mod_len = PTR_W'(mod_end_q - mod_start_q + PTR_W'(1));

    // Normal next pointer for each addressing mode
    always_comb begin
        case (req_mode)
            BRAG_MODE_PRE_INC,
            BRAG_MODE_POST_INC: raw_next = PTR_W'(req_ptr + step);
            BRAG_MODE_PRE_DEC,
            BRAG_MODE_POST_DEC: raw_next = PTR_W'(req_ptr - step);
            BRAG_MODE_OFFSET: raw_next = PTR_W'(req_ptr + req_offset);
            default: raw_next = req_ptr;
        endcase
    end

    // Modulo correction; boundaries compared as less/greater, not just equal
    always_comb begin
        mod_next = raw_next;
        if (use_mod) begin
            if ((inc_mode || req_mode == BRAG_MODE_OFFSET) && raw_next > mod_end_q) begin
                mod_next = PTR_W'(raw_next - mod_len);
            end else if ((dec_mode || req_mode == BRAG_MODE_OFFSET)
                && raw_next < mod_start_q) begin
                mod_next = PTR_W'(raw_next + mod_len);
            end
        end
    end

    // Reversed-carry sum on word addresses; pointer itself stays in normal order
    brag_rev_add #(
        .W(PTR_W - 1)
    ) u_rev_add (
        .a(req_ptr[PTR_W-1:1]), // RULE2
        .b(pivot_modifier),
        .sum(rev_word)
    );
    assign rev_next = {rev_word, 1'b0}; // RULE8

    // Reversal takes priority over modulo and replaces the mode's increment
    assign next_ptr = use_brev ? rev_next : mod_next; // RULE10 RULE11

    // Effective address: pre-modify and offset forms use the new value
    always_comb begin
        if (use_brev) begin
            ea_d = pre_mode ? rev_next : {req_ptr[PTR_W-1:1], 1'b0}; // RULE8
        end else if (pre_mode || req_mode == BRAG_MODE_OFFSET) begin
            ea_d = mod_next; // RULE13
        end else begin
            ea_d = req_ptr;
        end
    end

    // Pointer is written back only by pre/post modify forms
    assign wb_d = inc_mode || dec_mode; // RULE13

    // Address result pipeline, one cycle after the request
    // Nothing stalls a request: the answer appears at the next edge
    // whatever the register bus is doing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ea_valid_q <= 1'b0;
            ea_addr_q <= '0;
            ea_reversed_q <= 1'b0;
            wb_en_q <= 1'b0;
            wb_reg_q <= '0;
            wb_value_q <= '0;
        end else begin
            ea_valid_q <= req_valid;
            wb_en_q <= req_valid && wb_d;
            if (req_valid) begin
                ea_addr_q <= ea_d;
                ea_reversed_q <= use_brev;
                wb_reg_q <= req_wreg;
                wb_value_q <= next_ptr;
            end
        end
    end

    // Write address and data are taken independently, in either order
    // Each ready stays low from its take until the response handshake,
    // so at most one write is ever in flight
    assign aw_take = s_axi_awvalid && awready_q;
    assign w_take = s_axi_wvalid && wready_q;
    assign do_write = (aw_held_q || aw_take) && (w_held_q || w_take) && !bvalid_q;
    assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
    assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;

    // Write channel handshakes and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= BRAG_RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                awready_q <= 1'b0;
                wready_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? BRAG_RESP_OKAY : BRAG_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held_q <= 1'b1;
                    awready_q <= 1'b0;
                end
                if (w_take) begin
                    w_held_q <= 1'b1;
                    wready_q <= 1'b0;
                end
                if (bvalid_q && s_axi_bready) begin
                    bvalid_q <= 1'b0;
                    awready_q <= 1'b1;
                    wready_q <= 1'b1;
                end
            end
        end
    end

    // Address decode of writable registers
    always_comb begin
        case ({wr_addr[ADDR_W-1:2], 2'b00})
            ADDR_W'(BRAG_REV_CTRL_OFS),
            ADDR_W'(BRAG_MOD_CTRL_OFS),
            ADDR_W'(BRAG_MOD_START_OFS),
            ADDR_W'(BRAG_MOD_END_OFS): wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Register writes with byte lanes 0 and 1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rev_ctrl_q <= BRAG_REV_CTRL_RST;
            mod_ctrl_q <= BRAG_MOD_CTRL_RST;
            mod_start_q <= PTR_W'(BRAG_MOD_START_RST);
            mod_end_q <= PTR_W'(BRAG_MOD_END_RST);
        end else if (do_write) begin
            for (int b = 0; b < 2; b++) begin
                if (wr_strb[b]) begin
                    case ({wr_addr[ADDR_W-1:2], 2'b00})
                        ADDR_W'(BRAG_REV_CTRL_OFS): rev_ctrl_q[b*8 +: 8] <= wr_data[b*8 +: 8];
                        ADDR_W'(BRAG_MOD_CTRL_OFS): mod_ctrl_q[b*8 +: 8] <= wr_data[b*8 +: 8];
                        ADDR_W'(BRAG_MOD_START_OFS): mod_start_q[b*8 +: 8] <= wr_data[b*8 +: 8];
                        ADDR_W'(BRAG_MOD_END_OFS): mod_end_q[b*8 +: 8] <= wr_data[b*8 +: 8];
                        default: ;
                    endcase
                end
            end
        end
    end

    // Read decode; status shows the last generated address
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
            ADDR_W'(BRAG_REV_CTRL_OFS): rd_word[15:0] = rev_ctrl_q;
            ADDR_W'(BRAG_MOD_CTRL_OFS): rd_word[15:0] = mod_ctrl_q;
            ADDR_W'(BRAG_MOD_START_OFS): rd_word[PTR_W-1:0] = mod_start_q;
            ADDR_W'(BRAG_MOD_END_OFS): rd_word[PTR_W-1:0] = mod_end_q;
            ADDR_W'(BRAG_STATUS_OFS): begin
                rd_word[PTR_W-1:0] = ea_addr_q;
                rd_word[BRAG_STAT_REV_BIT] = ea_reversed_q;
                rd_word[BRAG_STAT_WB_BIT] = wb_en_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // Read channel: address taken, data one cycle later
    // Data is captured at the address edge; a later register change
    // does not alter a response still waiting for rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= BRAG_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? BRAG_RESP_OKAY : BRAG_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign ea_valid = ea_valid_q;
    assign ea_addr = ea_addr_q;
    assign ea_reversed = ea_reversed_q;
    assign ptr_wb_en = wb_en_q;
    assign ptr_wb_reg = wb_reg_q;
    assign ptr_wb_value = wb_value_q;

endmodule // brag_addr_gen

/* pkg/brag_pkg.sv */
// Constants shared by the bit-reversed address generator and its register slave
//
// Overview of operation
// (RULE1) Reversed addresses only in the write-side generator, only for data writes.
// (RULE2) Only the modifier is treated as reversed; pointer and results stay normal order.
// (RULE3) Reversal needs the pointer-select field to differ from 1111, the stack pointer.
// (RULE4) Reversal also needs reverse_enable, bit 15 of the reverse control register.
// (RULE5) Reversal also needs register indirect with pre-increment or post-increment.
// (RULE6) Software aligns a 2^N byte buffer so its low N start bits are zero.
// (RULE7) The pivot modifier is bits 14 to 0 of the reverse control register.
// (RULE8) Reversed addresses are word addresses; pivot scaled to bytes, bit 0 forced zero.
// (RULE9) Byte accesses and other addressing modes get normal addresses even when enabled.
// (RULE10) When reversing, pivot is added to the pointer; the mode's increment is ignored.
// (RULE11) Modulo and reversal may share a register; reversal wins on data writes.
// (RULE12) Software avoids an indirect read through the pointer right after a control write.
// (RULE13) Offset form gets modulo correction on the address but no pointer write-back.
// (RULE14) Next reversed pointer adds pivot with carries running from MSB toward LSB.
package brag_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] BRAG_REV_CTRL_OFS = 8'h00;
    localparam logic [7:0] BRAG_MOD_CTRL_OFS = 8'h04;
    localparam logic [7:0] BRAG_MOD_START_OFS = 8'h08;
    localparam logic [7:0] BRAG_MOD_END_OFS = 8'h0C;
    localparam logic [7:0] BRAG_STATUS_OFS = 8'h10;

    // Values after reset
    localparam logic [15:0] BRAG_REV_CTRL_RST = 16'h0000;
    localparam logic [15:0] BRAG_MOD_CTRL_RST = 16'h0000;
    localparam logic [15:0] BRAG_MOD_START_RST = 16'h0000;
    localparam logic [15:0] BRAG_MOD_END_RST = 16'hFFFF;

    // Field positions in the reverse-addressing control register
    localparam int BRAG_REVERSE_ENABLE_BIT = 15;
    localparam int BRAG_PIVOT_MSB = 14;
    localparam int BRAG_PIVOT_W = 15;

    // Field positions in the modulo control register
    localparam int BRAG_MOD_ENABLE_BIT = 15;
    localparam int BRAG_MOD_SEL_LSB = 4;
    localparam int BRAG_PTR_SEL_LSB = 0;
    localparam int BRAG_SEL_W = 4;

    // Pointer number of the stack pointer
    localparam logic [3:0] BRAG_STACK_PTR = 4'hF;

    // Status register field positions
    localparam int BRAG_STAT_REV_BIT = 16;
    localparam int BRAG_STAT_WB_BIT = 17;

    // Addressing mode codes from the execution unit
    localparam logic [2:0] BRAG_MODE_INDIRECT = 3'h0;
    localparam logic [2:0] BRAG_MODE_POST_DEC = 3'h1;
    localparam logic [2:0] BRAG_MODE_POST_INC = 3'h2;
    localparam logic [2:0] BRAG_MODE_PRE_DEC = 3'h4;
    localparam logic [2:0] BRAG_MODE_PRE_INC = 3'h5;
    localparam logic [2:0] BRAG_MODE_OFFSET = 3'h6;

    // AXI response codes
    localparam logic [1:0] BRAG_RESP_OKAY = 2'b00;
    localparam logic [1:0] BRAG_RESP_SLVERR = 2'b10;

endpackage

/* rtl/brag_rev_add.sv */
// Adder whose carry runs from the most significant bit toward bit 0
`timescale 1ns/1ps
module brag_rev_add #(
    parameter int W = 15
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    output logic [W-1:0] sum
);

    // Ripple from the top down, so the modifier acts as if bit reversed
    always_comb begin
        logic c;
        c = 1'b0;
        sum = '0;
        for (int i = W - 1; i >= 0; i--) begin
            sum[i] = a[i] ^ b[i] ^ c; // RULE14
            c = (a[i] & b[i]) | (a[i] & c) | (b[i] & c);
        end
    end

endmodule // brag_rev_add

/* test/brag_checker.sv */
// Port checker for the bit-reversed address generator
`timescale 1ns/1ps
module brag_checker
    import brag_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int PTR_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_byte,
    input wire logic [3:0] req_wreg,
    input wire logic [2:0] req_mode,
    input wire logic [PTR_W-1:0] req_ptr,
    input wire logic ea_valid,
    input wire logic [PTR_W-1:0] ea_addr,
    input wire logic ea_reversed,
    input wire logic ptr_wb_en,
    input wire logic [3:0] ptr_wb_reg,
    input wire logic [PTR_W-1:0] ptr_wb_value
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Request taken, then its answer one edge later
    sequence s_take;
        req_valid;
    endsequence
    sequence s_rev_out;
        ea_valid && ea_reversed;
    endsequence
    a_read_plain: assert property (s_take and !req_write |=> ea_valid && !ea_reversed)
        else $error("read used reversed address");
    a_byte_plain: assert property (s_take and req_byte |=> !ea_reversed)
        else $error("byte access used reversed address");
    a_mode_plain: assert property (s_take and req_mode != BRAG_MODE_POST_INC
        && req_mode != BRAG_MODE_PRE_INC |=> !ea_reversed)
        else $error("non-increment mode used reversed address");
    a_stack_plain: assert property (s_take and req_wreg == BRAG_STACK_PTR |=> !ea_reversed)
        else $error("stack pointer used reversed address");
    a_rev_even: assert property (s_rev_out |-> !ea_addr[0] && !ptr_wb_value[0])
        else $error("reversed address has bit 0 set");
    a_rev_wb: assert property (s_rev_out |-> ptr_wb_en && ptr_wb_reg == $past(req_wreg))
        else $error("reversed request without pointer write-back");
    a_pre_next: assert property (s_rev_out and $past(req_mode) == BRAG_MODE_PRE_INC
        |-> ea_addr == ptr_wb_value)
        else $error("reversed pre-increment address differs from new pointer");
    a_off_nowb: assert property (s_take and req_mode == BRAG_MODE_OFFSET
        |=> ea_valid && !ptr_wb_en)
        else $error("offset form wrote the pointer back");
    a_post_src: assert property (s_take and req_mode == BRAG_MODE_POST_INC
        |=> ea_addr[PTR_W-1:1] == $past(req_ptr[PTR_W-1:1]))
        else $error("post-increment address not the pointer");
    a_wb_pulse: assert property (ptr_wb_en |-> ea_valid && $past(req_valid))
        else $error("write-back pulse without request");
endmodule // brag_checker

/* test/brag_exec_model.sv */
// Execution-unit model that issues address requests
`timescale 1ns/1ps
module brag_exec_model (
    output logic req_valid,
    output logic req_write,
    output logic req_byte,
    output logic [3:0] req_wreg,
    output logic [2:0] req_mode,
    output logic [15:0] req_ptr,
    output logic [15:0] req_offset
);
    initial begin
        {req_valid, req_write, req_byte, req_wreg, req_mode, req_ptr, req_offset} = '0;
    end
    // Fields only qualify a pulse; between pulses they toggle so nothing stale looks valid
    task automatic drive(input logic v, w, b, input logic [3:0] r, input logic [2:0] m,
        input logic [15:0] p, o);
        req_valid <= v;
        if (v) begin
            {req_write, req_byte, req_wreg, req_mode, req_ptr, req_offset} <= {w, b, r, m, p, o};
        end else begin
            {req_write, req_byte, req_wreg, req_mode, req_ptr, req_offset} <=
                ~{req_write, req_byte, req_wreg, req_mode, req_ptr, req_offset};
        end
    endtask
endmodule // brag_exec_model

/* test/test_bit_reversed_address_gen.sv */
// Self-checking bench for the bit-reversed address generator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_bit_reversed_address_gen;
    import brag_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, req_wreg, ptr_wb_reg;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic req_valid, req_write, req_byte, ea_valid, ea_reversed, ptr_wb_en;
    logic [2:0] req_mode;
    logic [15:0] req_ptr, req_offset, ea_addr, ptr_wb_value;
    logic [15:0] rev_ctrl, mod_ctrl;
    int mismatches = 0;
    int n_tests = 0;
    localparam logic [15:0] MSTART = 16'h1000; // 256-byte buffer, low 8 bits zero
    localparam logic [15:0] MEND = 16'h10FF;
    brag_addr_gen brag_addr_gen_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'b000),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'b000), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .req_valid, .req_write, .req_byte, .req_wreg, .req_mode,
        .req_ptr, .req_offset, .ea_valid, .ea_addr, .ea_reversed, .ptr_wb_en, .ptr_wb_reg,
        .ptr_wb_value);
    brag_exec_model brag_exec_model_i (.req_valid, .req_write, .req_byte, .req_wreg,
        .req_mode, .req_ptr, .req_offset);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Master write: both channels offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, done;
        done = 1'b0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (int n = 0; n < 40 && !done; n++) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready === 1'b1;
            tw = s_axi_wvalid && s_axi_wready === 1'b1;
            done = s_axi_bvalid === 1'b1;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (done) s_axi_bready <= 1'b0;
        end
        if (!done) begin
            mismatches++;
            report_and_stop();
        end
    endtask
    // Master read: address held until taken, rready held until data seen
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, done;
        done = 1'b0;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        for (int n = 0; n < 40 && !done; n++) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready === 1'b1;
            done = s_axi_rvalid === 1'b1;
            {d, r} = {s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (done) s_axi_rready <= 1'b0;
        end
        if (!done) begin
            mismatches++;
            report_and_stop();
        end
    endtask
    function automatic logic [14:0] flip15(input logic [14:0] x);
        logic [14:0] y;
        for (int k = 0; k < 15; k++) y[k] = x[14-k];
        return y;
    endfunction
    // Expected answer worked out from the current register copies
    function automatic void expect_req(input logic w, b, input logic [3:0] r,
        input logic [2:0] m, input logic [15:0] p, o,
        output logic [15:0] ea, nx, output logic rv, wb);
        logic inc, dec, ofs;
        inc = m == BRAG_MODE_POST_INC || m == BRAG_MODE_PRE_INC;
        dec = m == BRAG_MODE_POST_DEC || m == BRAG_MODE_PRE_DEC;
        ofs = m == BRAG_MODE_OFFSET;
        rv = w && !b && inc && rev_ctrl[15] && mod_ctrl[3:0] != 4'hF && r == mod_ctrl[3:0];
        wb = inc || dec;
        if (rv) begin
            nx = {flip15(flip15(p[15:1]) + flip15(rev_ctrl[14:0])), 1'b0};
            ea = (m == BRAG_MODE_PRE_INC) ? nx : {p[15:1], 1'b0};
        end else begin
            nx = inc ? p + (b ? 16'h0001 : 16'h0002) : dec ? p - (b ? 16'h0001 : 16'h0002) :
                ofs ? p + o : p;
            if (mod_ctrl[15] && r == mod_ctrl[7:4]) begin
                if ((inc || ofs) && nx > MEND) nx = nx - (MEND - MSTART + 16'h0001);
                if ((dec || ofs) && nx < MSTART) nx = nx + (MEND - MSTART + 16'h0001);
            end
            ea = (m == BRAG_MODE_PRE_INC || m == BRAG_MODE_PRE_DEC || ofs) ? nx : p;
        end
    endfunction
    // Main sequence: reset, register map, then random request traffic per setting
    initial begin
        logic [31:0] d;
        logic [1:0] rs;
        logic [15:0] e_ea, e_nx, p, o, lea;
        logic e_rv, e_wb, pv, v, w, b, lrv;
        logic [3:0] r, ps, e_rg;
        logic [7:0] ofs [4] = '{BRAG_REV_CTRL_OFS, BRAG_MOD_CTRL_OFS, BRAG_MOD_START_OFS,
            BRAG_MOD_END_OFS};
        logic [15:0] rst [4] = '{BRAG_REV_CTRL_RST, BRAG_MOD_CTRL_RST, BRAG_MOD_START_RST,
            BRAG_MOD_END_RST};
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        void'($urandom(31914));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            axi_rd(ofs[k], d, rs);
            `CHK("reset value", {16'h0000, rst[k]}, d)
        end
        axi_rd(8'h14, d, rs);
        `CHK("unmapped read resp", BRAG_RESP_SLVERR, rs)
        axi_wr(BRAG_STATUS_OFS, 32'h0000_FFFF, rs);
        `CHK("status write resp", BRAG_RESP_SLVERR, rs)
        axi_wr(BRAG_MOD_START_OFS, {16'h0000, MSTART}, rs);
        axi_wr(BRAG_MOD_END_OFS, {16'h0000, MEND}, rs);
        for (int c = 0; c < 6; c++) begin
            ps = (c == 1) ? 4'hF : (c == 0) ? 4'h3 : 4'($urandom);
            rev_ctrl = {(c != 2) ? 1'b1 : 1'b0, (c == 4) ? 15'h7FFF : 15'($urandom)};
            mod_ctrl = {(c == 0) ? 1'b1 : 1'($urandom), 7'h00, (c == 0) ? 4'h3 : 4'($urandom), ps};
            axi_wr(BRAG_REV_CTRL_OFS, {16'h0000, rev_ctrl}, rs);
            `CHK("rev ctrl write resp", BRAG_RESP_OKAY, rs)
            axi_wr(BRAG_MOD_CTRL_OFS, {16'h0000, mod_ctrl}, rs);
            `CHK("mod ctrl write resp", BRAG_RESP_OKAY, rs)
            axi_rd(BRAG_REV_CTRL_OFS, d, rs);
            `CHK("rev ctrl readback", {16'h0000, rev_ctrl}, d)
            `CHK("rev ctrl read resp", BRAG_RESP_OKAY, rs)
            axi_rd(BRAG_MOD_CTRL_OFS, d, rs);
            `CHK("mod ctrl readback", {16'h0000, mod_ctrl}, d)
            pv = 1'b0;
            for (int i = 0; i <= 80; i++) begin
                @(posedge aclk);
                v = (i < 80) && ($urandom_range(0, 3) != 0);
                w = (i == 0) || 1'($urandom); // Slot 0 after the control writes is a write, but it is valid only at random
                b = $urandom_range(0, 3) == 0;
                r = $urandom_range(0, 1) ? ps : 4'($urandom);
                p = MSTART + 16'($urandom_range(0, 255));
                o = 16'($urandom_range(0, 255));
                brag_exec_model_i.drive(v, w, b, r, 3'($urandom), p, o);
                #1;
                `CHK("ea_valid", pv, ea_valid)
                if (pv) begin
                    `CHK("ea_addr", e_ea, ea_addr)
                    `CHK("ea_reversed", e_rv, ea_reversed)
                    `CHK("ptr_wb_reg", e_rg, ptr_wb_reg)
                    `CHK("ptr_wb_en", e_wb, ptr_wb_en)
                    if (e_wb) `CHK("ptr_wb_value", e_nx, ptr_wb_value)
                    lea = e_ea;
                    lrv = e_rv;
                end
                pv = v;
                expect_req(w, b, r, req_mode, p, o, e_ea, e_nx, e_rv, e_wb);
                e_rg = r;
            end
            axi_rd(BRAG_STATUS_OFS, d, rs);
            `CHK("status last address", lea, d[15:0])
            `CHK("status flags", {1'b0, lrv}, d[17:16])
        end
        report_and_stop();
    end
endmodule // test_bit_reversed_address_gen
bind brag_addr_gen brag_checker #(.ADDR_W(ADDR_W), .PTR_W(PTR_W)) brag_checker_i (.aclk,
    .aresetn, .req_valid, .req_write, .req_byte, .req_wreg, .req_mode, .req_ptr, .ea_valid,
    .ea_addr, .ea_reversed, .ptr_wb_en, .ptr_wb_reg, .ptr_wb_value);
